// File: design/hppm_top.v
// host parallel port with memory window and mailbox
`timescale 1ns/1ps
`include "hppm_map.vh"
// Behaviour
// - two address bits select four port registers
// - sixteen data bits per access
// - low strobes, access taken at rising edge
// - pointer advances after each data access
// - host reaches all internal memory directly
// - two mailboxes, one each way: host to device and device to host
// - interrupt flags outgoing mailbox message waiting
// - status register readable at code 11
module hppm_top #(
  parameter AW = 13
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_port_select_low,
  input wire i_read_strobe_low,
  input wire i_write_strobe_low,
  input wire [1:0] i_port_addr,
  input wire [15:0] i_port_data,
  output reg [15:0] o_port_data,
  output reg o_port_data_oe_b,
  output reg o_host_mailbox_irq,
  input wire i_fw_mbox_we,
  input wire [15:0] i_fw_mbox_wdata,
  input wire i_fw_mbox_re,
  input wire i_fw_busy,
  input wire i_byte_swap,
  output reg [15:0] o_fw_mbox_rdata,
  output reg o_fw_mbox_new
);
  // ************************************************************
  // reset release
  // ************************************************************
  // two flops so the release never lands close to a clock edge
  reg rst_s1_r;
  reg rst_b_r;
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else if (i_ce) begin
      rst_s1_r <= 1'b1;
      rst_b_r <= rst_s1_r;
    end
  end
  // ************************************************************
  // strobe edge detect
  // ************************************************************
  reg rd_d_r;
  reg wr_d_r;
  wire rd_act = !i_port_select_low && !i_read_strobe_low;
  wire wr_act = !i_port_select_low && !i_write_strobe_low;
  // capture at the rising (trailing) edge so address and data are settled
  wire rd_done = rd_d_r && !rd_act;
  wire wr_done = wr_d_r && !wr_act;
  reg [1:0] sel_r;
  reg [15:0] wd_r;
  function [15:0] swap16;
    input [15:0] v;
    input en;
    begin
      swap16 = en ? {v[7:0], v[15:8]} : v;
    end
  endfunction

  // ************************************************************
  // helper functions
  // ************************************************************
  // true when a finished access went to the given port register
  function sel_hit;
    input done;
    input [1:0] sel;
    input [1:0] code;
    begin
      sel_hit = done && (sel == code);
    end
  endfunction

  // status word from its flag positions; unused bits read zero
  function [15:0] status_pack;
    input out_full;
    input in_full;
    input fw_busy;
    input byte_swap;
    reg [15:0] s;
    begin
      s = `HPPM_RST_WORD;
      s[`HPPM_ST_OUT_FULL] = out_full;
      s[`HPPM_ST_IN_FULL] = in_full;
      s[`HPPM_ST_FW_BUSY] = fw_busy;
      s[`HPPM_ST_SWAP] = byte_swap;
      status_pack = s;
    end
  endfunction

  // ************************************************************
  // access capture
  // ************************************************************
  reg [1:0] sel_nxt;
  reg [15:0] wd_nxt;
  // last sampled address and data win, so late settling is harmless
  always @* begin
    sel_nxt = sel_r;
    wd_nxt = wd_r;
    if (rd_act || wr_act) begin
      sel_nxt = i_port_addr;
    end
    if (wr_act) begin
      wd_nxt = i_port_data;
    end
  end

  always @(posedge i_ref_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
    end else if (i_ce) begin
      rd_d_r <= rd_act;
      wr_d_r <= wr_act;
    end
  end

  always @(posedge i_ref_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      sel_r <= `HPPM_SEL_DATA;
      wd_r <= `HPPM_RST_WORD;
    end else if (i_ce) begin
      sel_r <= sel_nxt;
      wd_r <= wd_nxt;
    end
  end

  wire rd_data = sel_hit(rd_done, sel_r, `HPPM_SEL_DATA);
  wire wr_data = sel_hit(wr_done, sel_r, `HPPM_SEL_DATA);
  wire rd_mbox = sel_hit(rd_done, sel_r, `HPPM_SEL_MBOX);
  wire wr_mbox = sel_hit(wr_done, sel_r, `HPPM_SEL_MBOX);
  wire wr_addr = sel_hit(wr_done, sel_r, `HPPM_SEL_ADDR);

  // ************************************************************
  // memory window
  // ************************************************************
  reg [15:0] ptr_r;
  reg [15:0] ptr_nxt;
  reg mem_pend_r;
  wire [15:0] mem_rdata;
  wire [15:0] mem_wdata = swap16(wd_r, i_byte_swap);
  // prefetch at the pointer when a read strobe starts so data is ready;
  // a strobe shorter than two cycles would return the old word
  wire rd_start = sel_hit(rd_act && !rd_d_r, i_port_addr, `HPPM_SEL_DATA);
  hppm_mem #(
    .DW(16),
    .AW(AW)
  ) hppm_mem_i (
    .i_ref_clk(i_ref_clk),
    .i_ce(i_ce),
    .i_we(wr_data),
    .i_re(rd_start),
    .i_addr(ptr_r[AW-1:0]),
    .i_wdata(mem_wdata),
    .o_rdata(mem_rdata)
  );

  // pointer keeps 16 bits; only its low AW bits reach the memory
  always @* begin
    ptr_nxt = ptr_r;
    if (wr_addr) begin
      ptr_nxt = wd_r;
    end else if (rd_data || wr_data) begin
      ptr_nxt = ptr_r + 16'h0001;
    end
  end

  always @(posedge i_ref_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      ptr_r <= `HPPM_RST_WORD;
      mem_pend_r <= 1'b0;
    end else if (i_ce) begin
      ptr_r <= ptr_nxt;
      mem_pend_r <= rd_start;
    end
  end

  // ************************************************************
  // mailboxes
  // ************************************************************
  reg [15:0] mbox_in_r;
  reg [15:0] mbox_in_nxt;
  reg in_full_r;
  reg in_full_nxt;
  reg [15:0] mbox_out_r;
  reg [15:0] mbox_out_nxt;
  reg out_full_r;
  reg out_full_nxt;
  // host to device; a new host word beats the firmware clear
  always @* begin
    mbox_in_nxt = mbox_in_r;
    in_full_nxt = in_full_r;
    if (wr_mbox) begin
      mbox_in_nxt = wd_r;
      in_full_nxt = 1'b1;
    end else if (i_fw_mbox_re) begin
      in_full_nxt = 1'b0;
    end
  end

  // device to host; a firmware write beats the host read clear
  always @* begin
    mbox_out_nxt = mbox_out_r;
    out_full_nxt = out_full_r;
    if (i_fw_mbox_we) begin
      mbox_out_nxt = i_fw_mbox_wdata;
      out_full_nxt = 1'b1;
    end else if (rd_mbox) begin
      out_full_nxt = 1'b0;
    end
  end

  always @(posedge i_ref_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      mbox_in_r <= `HPPM_RST_WORD;
      in_full_r <= 1'b0;
    end else if (i_ce) begin
      mbox_in_r <= mbox_in_nxt;
      in_full_r <= in_full_nxt;
    end
  end

  always @(posedge i_ref_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      mbox_out_r <= `HPPM_RST_WORD;
      out_full_r <= 1'b0;
    end else if (i_ce) begin
      mbox_out_r <= mbox_out_nxt;
      out_full_r <= out_full_nxt;
    end
  end

  // ************************************************************
  // read data path
  // ************************************************************
  wire [15:0] status_w;
  assign status_w = status_pack(out_full_r, in_full_r, i_fw_busy,
    i_byte_swap);
  reg [15:0] port_data_nxt;
  reg port_data_oe_b_nxt;

  // the bus word holds between reads so a slow host can sample late
  always @* begin
    port_data_nxt = o_port_data;
    port_data_oe_b_nxt = !rd_act;
    if (rd_act) begin
      case (i_port_addr)
        `HPPM_SEL_DATA: begin
          if (mem_pend_r) begin
            port_data_nxt = swap16(mem_rdata, i_byte_swap);
          end
        end
        `HPPM_SEL_MBOX: begin
          port_data_nxt = mbox_out_r;
        end
        `HPPM_SEL_ADDR: begin
          port_data_nxt = ptr_r;
        end
        `HPPM_SEL_STAT: begin
          port_data_nxt = status_w;
        end
        default: begin
          port_data_nxt = `HPPM_RST_WORD;
        end
      endcase
    end
  end

  // ************************************************************
  // output registers
  // ************************************************************
  always @(posedge i_ref_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      o_port_data <= `HPPM_RST_WORD;
      o_port_data_oe_b <= 1'b1;
    end else if (i_ce) begin
      o_port_data <= port_data_nxt;
      o_port_data_oe_b <= port_data_oe_b_nxt;
    end
  end

  always @(posedge i_ref_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      o_host_mailbox_irq <= 1'b0;
    end else if (i_ce) begin
      o_host_mailbox_irq <= out_full_r;
    end
  end

  always @(posedge i_ref_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      o_fw_mbox_rdata <= `HPPM_RST_WORD;
      o_fw_mbox_new <= 1'b0;
    end else if (i_ce) begin
      o_fw_mbox_rdata <= mbox_in_r;
      o_fw_mbox_new <= in_full_r;
    end
  end
endmodule // hppm_top

// File: design/hppm_map.vh
// constants for the host parallel port mailbox block
`ifndef HPPM_MAP_VH
`define HPPM_MAP_VH
// ************************************************************
// port register select codes
// ************************************************************
`define HPPM_SEL_DATA 2'h0
`define HPPM_SEL_MBOX 2'h1
`define HPPM_SEL_ADDR 2'h2
`define HPPM_SEL_STAT 2'h3
// ************************************************************
// status field positions
// ************************************************************
`define HPPM_ST_OUT_FULL 0
`define HPPM_ST_IN_FULL 1
`define HPPM_ST_FW_BUSY 2
`define HPPM_ST_SWAP 3
// ************************************************************
// reset values
// ************************************************************
`define HPPM_RST_WORD 16'h0000
`endif

// File: design/hppm_mem.v
// single-port word memory with registered read data
`timescale 1ns/1ps
module hppm_mem #(
  parameter DW = 16,
  parameter AW = 13
) (
  input wire i_ref_clk,
  input wire i_ce,
  input wire i_we,
  input wire i_re,
  input wire [AW-1:0] i_addr,
  input wire [DW-1:0] i_wdata,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // no reset on the array; read data register starts unknown until read
  always @(posedge i_ref_clk) begin
    if (i_ce) begin
      if (i_we) begin
        mem[i_addr] <= i_wdata;
      end
      if (i_re) begin
        o_rdata <= mem[i_addr];
      end
    end
  end
endmodule // hppm_mem

// File: bench/hppm_properties.sv
// assertions on the host parallel port pins
`timescale 1ns/1ps
module hppm_properties(
  input wire i_ref_clk, i_rst_b, i_ce, i_port_select_low,
  input wire i_read_strobe_low, i_write_strobe_low, i_fw_mbox_we,
  input wire i_fw_mbox_re, o_port_data_oe_b, o_host_mailbox_irq,
  input wire o_fw_mbox_new, input wire [1:0] i_port_addr,
  input wire [15:0] o_port_data);
  default clocking @(posedge i_ref_clk); endclocking
  // ce low freezes all state, so nothing is judged then
  default disable iff (!i_rst_b || !i_ce);
  wire rd = !i_port_select_low && !i_read_strobe_low;
  wire wr = !i_port_select_low && !i_write_strobe_low;
  wire mb = i_port_addr == 2'h1;
  wire we = i_fw_mbox_we;
  wire irq = o_host_mailbox_irq;
  wire oe = o_port_data_oe_b;
  sequence s_rd; rd && mb && !we ##1 !rd && !we; endsequence
  sequence s_wr; wr && mb ##1 !wr; endsequence
  a_irq_rise: assert property (we |-> ##2 irq)
    else $error("irq not raised");
  a_irq_cause: assert property ($rose(irq) |-> $past(we, 2))
    else $error("irq without message");
  a_irq_clear: assert property (s_rd |-> ##2 !irq)
    else $error("irq kept after read");
  a_oe_read: assert property (rd |=> !oe)
    else $error("bus not driven");
  a_oe_idle: assert property (!rd [*2] |=> oe)
    else $error("bus driven when idle");
  a_data_hold: assert property (!$stable(o_port_data) |->
    !oe || !$past(oe)) else $error("read data moved");
  a_new_set: assert property (s_wr |-> ##[1:2] o_fw_mbox_new)
    else $error("inbound flag not set");
  a_new_clr: assert property (i_fw_mbox_re && !wr && !$past(wr) |->
    ##[1:2] !o_fw_mbox_new) else $error("inbound flag kept");
endmodule // hppm_properties
bind hppm_top hppm_properties hppm_properties_i(.i_ref_clk, .i_rst_b,
  .i_ce, .i_port_select_low, .i_read_strobe_low, .i_write_strobe_low,
  .i_fw_mbox_we, .i_fw_mbox_re, .o_port_data_oe_b, .o_host_mailbox_irq,
  .o_fw_mbox_new, .i_port_addr, .o_port_data);

// File: bench/hppm_host.sv
// host processor model on the parallel port
`timescale 1ns/1ps
module hppm_host(
  input wire clk,
  input wire [15:0] q,
  output reg cs_low = 1'h1, rd_low = 1'h1, wr_low = 1'h1,
  output reg [1:0] a = 2'h0,
  output reg [15:0] d = 16'h0);
  // strobe held five cycles so the window prefetch has landed
  task acc(input w, input [1:0] ad, input [15:0] wd, output [15:0] rv);
    @(posedge clk) #1;
    {cs_low, a, d} = {1'h0, ad, wd};
    {rd_low, wr_low} = {w, !w};
    repeat (5) @(posedge clk);
    #1 rv = q;
    {cs_low, rd_low, wr_low} = 3'h7;
    d = ~d;
    @(posedge clk) #1;
  endtask
endmodule // hppm_host

// File: bench/test_hppm_top.sv
// self-checking bench for the host parallel port
`timescale 1ns/1ps
module test_hppm_top;
  reg clk = 0, rst_b = 0, fwe = 0, fre = 0, busy = 0, swp = 0, ce = 1;
  reg [15:0] fwd = 16'h0, v, p, w;
  reg [15:0] m [0:3];
  integer err_count = 0, n_checks = 0, i;
  wire cs, rd, wr, oe, irq, fnew;
  wire [1:0] a;
  wire [15:0] hd, q, fq;
  wire [15:0] bus = oe ? hd : q;
  hppm_top hppm_top_i(.i_ref_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
    .i_port_select_low(cs), .i_read_strobe_low(rd),
    .i_write_strobe_low(wr), .i_port_addr(a), .i_port_data(bus),
    .o_port_data(q), .o_port_data_oe_b(oe), .o_host_mailbox_irq(irq),
    .i_fw_mbox_we(fwe), .i_fw_mbox_wdata(fwd), .i_fw_mbox_re(fre),
    .i_fw_busy(busy), .i_byte_swap(swp), .o_fw_mbox_rdata(fq),
    .o_fw_mbox_new(fnew));
  hppm_host hppm_host_i(.clk(clk), .q(bus), .cs_low(cs), .rd_low(rd),
    .wr_low(wr), .a(a), .d(hd));
  initial forever #10 clk = ~clk;
  task chk(input string nm, input [16:0] s, e);
    n_checks++;
    if (s !== e) err_count++;
    if (s !== e) $display("MISMATCH %s exp %h got %h", nm, e, s);
  endtask
  task hold(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // whole run needs some one hundred sixty cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    summarize;
  end
  initial begin
    v = $urandom(32'h7e71bed9);
    hold(8);
    rst_b = 1;
    hold(4);
    hppm_host_i.acc(0, 2'h3, 16'h0, v);
    chk("st_rst", v, 17'h0);
    p = $urandom & 16'h1ff0;
    hppm_host_i.acc(1, 2'h2, p, v);
    for (i = 0; i < 4; i++) begin
      m[i] = $urandom;
      swp = i[0];
      hppm_host_i.acc(1, 2'h0, m[i], v);
    end
    swp = 0;
    hppm_host_i.acc(0, 2'h2, 16'h0, v);
    chk("ptr", v, p + 17'h4);
    hppm_host_i.acc(1, 2'h2, p, v);
    for (i = 0; i < 4; i++) begin
      hppm_host_i.acc(0, 2'h0, 16'h0, v);
      chk("mem", v, i[0] ? {m[i][7:0], m[i][15:8]} : m[i]);
    end
    $display("memory stream done");
    w = $urandom;
    hppm_host_i.acc(1, 2'h1, w, v);
    hold(1);
    chk("inbound", {fnew, fq}, {1'h1, w});
    fre = 1;
    hold(1);
    fre = 0;
    fwd = $urandom;
    busy = 1;
    fwe = 1;
    hold(1);
    fwe = 0;
    hold(2);
    chk("irq_set", {fnew, 15'h0, irq}, 17'h1);
    hppm_host_i.acc(0, 2'h3, 16'h0, v);
    chk("status", v, 17'h5);
    hppm_host_i.acc(0, 2'h1, 16'h0, v);
    chk("outbound", v, fwd);
    hold(3);
    chk("irq_clr", {16'h0, irq}, 17'h0);
    ce = 0;
    fwe = 1;
    hold(1);
    fwe = 0;
    ce = 1;
    hold(3);
    chk("ce_frozen", {16'h0, irq}, 17'h0);
    swp = 1;
    hppm_host_i.acc(1, 2'h3, 16'hffff, v);
    hppm_host_i.acc(0, 2'h3, 16'h0, v);
    chk("st_ro", v, 17'hc);
    hppm_host_i.acc(1, 2'h2, p, v);
    hppm_host_i.acc(0, 2'h0, 16'h0, v);
    chk("mem_swap", v, {m[0][7:0], m[0][15:8]});
    $display("mailbox and status done");
    summarize;
  end
endmodule // test_hppm_top
